// ### amp_pkg.sv
// Shared constants, register map and types for the amplifier control bank
package amp_pkg;

    // Bus filter and deglitch timing at 50 MHz
    localparam int unsigned CLK_PERIOD_NS   = 20;
    localparam int unsigned BUS_FILTER_NS   = 100;
    localparam int unsigned DEGLITCH_NS     = 1000;
    localparam int unsigned BUS_FILTER_CYC  = (BUS_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DEGLITCH_CYC    = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Bus address bytes
    localparam logic [7:0] ADDR_WRITE       = 8'hB0;
    localparam logic [7:0] ADDR_READ        = 8'hB1;

    // Register offsets
    localparam logic [7:0] REG_FUNCTION     = 8'h01;
    localparam logic [7:0] REG_ATTACK       = 8'h02;
    localparam logic [7:0] REG_RELEASE      = 8'h03;
    localparam logic [7:0] REG_HOLD         = 8'h04;
    localparam logic [7:0] REG_GAIN         = 8'h05;
    localparam logic [7:0] REG_LIMITER      = 8'h06;
    localparam logic [7:0] REG_MAXGAIN      = 8'h07;

    // Values after reset
    localparam logic [7:0] RST_FUNCTION     = 8'hC3;
    localparam logic [7:0] RST_ATTACK       = 8'h05;
    localparam logic [7:0] RST_RELEASE      = 8'h0B;
    localparam logic [7:0] RST_HOLD         = 8'h00;
    localparam logic [7:0] RST_GAIN         = 8'h06;
    localparam logic [7:0] RST_LIMITER      = 8'h3A;
    localparam logic [7:0] RST_MAXGAIN      = 8'hC2;

    // Field positions in the function control register
    localparam int unsigned BIT_RIGHT_ON    = 7;
    localparam int unsigned BIT_LEFT_ON     = 6;
    localparam int unsigned BIT_SHUTDOWN    = 5;
    localparam int unsigned BIT_FAULT_R     = 4;
    localparam int unsigned BIT_FAULT_L     = 3;
    localparam int unsigned BIT_THERMAL     = 2;
    localparam int unsigned BIT_FIXED_ONE   = 1;
    localparam int unsigned BIT_GATE_ON     = 0;

    // Compression ratio code meaning 1:1
    localparam logic [1:0] RATIO_ONE_TO_ONE = 2'h0;

    // Bit count of a full byte
    localparam logic [3:0] BYTE_BITS        = 4'h8;

    // Gain compression settings as seen by the audio path
    typedef struct packed {
        logic [5:0] gain_drop_interval;
        logic [5:0] gain_rise_interval;
        logic [5:0] hold_interval;
        logic [5:0] base_gain;
        logic       limiter_off;
        logic [1:0] gate_threshold;
        logic [4:0] limiter_level;
        logic [3:0] max_gain;
        logic [1:0] ratio;
    } amp_cfg_t;

    localparam amp_cfg_t CFG_RESET = '{
        gain_drop_interval: RST_ATTACK[5:0],
        gain_rise_interval: RST_RELEASE[5:0],
        hold_interval:      RST_HOLD[5:0],
        base_gain:          RST_GAIN[5:0],
        limiter_off:        RST_LIMITER[7],
        gate_threshold:     RST_LIMITER[6:5],
        limiter_level:      RST_LIMITER[4:0],
        max_gain:           RST_MAXGAIN[7:4],
        ratio:              RST_MAXGAIN[1:0]
    };

    // Hardware events after synchronising and deglitching
    typedef struct packed {
        logic fault_right;
        logic fault_left;
        logic over_temp;
    } amp_evt_t;

    // Serial bus slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_INDEX,
        ST_WRITE_ACK,
        ST_WRITE,
        ST_READ,
        ST_READ_ACK
    } amp_state_t;

endpackage : amp_pkg

// ### amp_sync_filter.sv
// Two-stage synchroniser followed by a per-bit stability filter
`timescale 1ns/1ps
module amp_sync_filter
    import amp_pkg::*;
#(
    parameter int unsigned     W       = 1,
    parameter int unsigned     CNT     = 2,
    parameter logic [W-1:0]    RST_VAL = '0
)(
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [W-1:0]  raw,
    output logic      [W-1:0]  clean
);

    localparam int unsigned    CW      = $clog2(CNT + 1);
    localparam logic [CW-1:0]  LAST    = CW'(CNT - 1);

    logic [W-1:0]  meta;
    logic [W-1:0]  stable;
    logic [CW-1:0] cnt [W];
    logic [CW-1:0] next_cnt [W];
    logic [W-1:0]  next_clean;

    // A bit follows its input only after it held steady for CNT cycles
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            next_cnt[i]   = '0;
            next_clean[i] = clean[i];
            if (stable[i] != clean[i])
            begin
                if (cnt[i] == LAST)
                    next_clean[i] = stable[i];
                else
                    next_cnt[i] = cnt[i] + 1'b1;
            end
        end
    end

    // Synchroniser stages, counters and filtered value
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta   <= RST_VAL;
            stable <= RST_VAL;
            clean  <= RST_VAL;
            for (int i = 0; i < W; i++)
                cnt[i] <= '0;
        end
        else
        begin
            meta   <= raw;
            stable <= meta;
            clean  <= next_clean;
            for (int i = 0; i < W; i++)
                cnt[i] <= next_cnt[i];
        end
    end

endmodule : amp_sync_filter

// ### amp_control_bank.sv
// Serial-bus control and status register bank of the stereo amplifier
//
// How it works
// - bits 7/6 enable right/left channel
// - over-temperature gates channels, they resume after
// - bit 5 set means whole device shut down
// - bits 4/3 latch channel faults until cleared
// - bit 2 sets when die overheats
// - thermal flag deglitched, latched, software clears it
// - bit 0 gate enable, only when ratio not 1:1
// - registers 2-4 six-bit times, top bits zero
// - registers 5-7 hold gain, limiter, ratio fields
// - power-up defaults C3,05,0B,00,06,3A,C2
// - answers address bytes B0 write, B1 read
// - write bytes fill consecutive registers from index
// - read bytes advance while master acknowledges
`timescale 1ns/1ps
module amp_control_bank
    import amp_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rstn,
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    output logic       sda_out,
    output logic       sda_oe,
    input  wire logic  fault_right_evt,
    input  wire logic  fault_left_evt,
    input  wire logic  over_temp_in,
    output logic       right_channel_active,
    output logic       left_channel_active,
    output logic       core_enabled,
    output logic       noise_gate_active,
    output amp_cfg_t   cfg_out
);

    logic [1:0]  bus_clean;
    amp_evt_t    evt;
    logic        scl;
    logic        sda;
    logic        scl_q;
    logic        sda_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;

    amp_state_t  state;
    amp_state_t  next_state;
    logic [3:0]  bitcnt;
    logic [3:0]  next_bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  next_shreg;
    logic [7:0]  index;
    logic [7:0]  next_index;
    logic        drive;
    logic        next_drive;
    logic        nack;
    logic        next_nack;
    logic        wr_en;
    logic [7:0]  rdata;

    logic        right_on;
    logic        left_on;
    logic        soft_shutdown;
    logic        fault_r;
    logic        fault_l;
    logic        thermal;
    logic        noise_gate_on;
    amp_cfg_t    cfg;
    logic        next_right_on;
    logic        next_left_on;
    logic        next_soft_shutdown;
    logic        next_fault_r;
    logic        next_fault_l;
    logic        next_thermal;
    logic        next_noise_gate_on;
    amp_cfg_t    next_cfg;

    // Bus pins: synchronised and glitch filtered, idle high
    amp_sync_filter #(
        .W       (2),
        .CNT     (BUS_FILTER_CYC),
        .RST_VAL (2'h3)
    ) u_bus_filter (
        .clk     (clk),
        .rstn    (rstn),
        .raw     ({scl_in, sda_in}),
        .clean   (bus_clean)
    );

    // Fault and temperature inputs: synchronised and deglitched
    amp_sync_filter #(
        .W       (3),
        .CNT     (DEGLITCH_CYC),
        .RST_VAL (3'h0)
    ) u_evt_filter (
        .clk     (clk),
        .rstn    (rstn),
        .raw     ({fault_right_evt, fault_left_evt, over_temp_in}),
        .clean   (evt)
    );

    // Bus edges and start/stop conditions
    assign scl       = bus_clean[1];
    assign sda       = bus_clean[0];
    assign scl_rise  = scl & ~scl_q;
    assign scl_fall  = ~scl & scl_q;
    assign bus_start = scl & scl_q & sda_q & ~sda;
    assign bus_stop  = scl & scl_q & ~sda_q & sda;

    // Read data mux; unused bits read zero except function bit 1, which reads one; unmapped offsets read zero
    always_comb
    begin
        case (index)
            REG_FUNCTION: rdata = {right_on, left_on, soft_shutdown, fault_r, fault_l,
                                   thermal, 1'b1, noise_gate_on};
            REG_ATTACK:   rdata = {2'h0, cfg.gain_drop_interval};
            REG_RELEASE:  rdata = {2'h0, cfg.gain_rise_interval};
            REG_HOLD:     rdata = {2'h0, cfg.hold_interval};
            REG_GAIN:     rdata = {2'h0, cfg.base_gain};
            REG_LIMITER:  rdata = {cfg.limiter_off, cfg.gate_threshold, cfg.limiter_level};
            REG_MAXGAIN:  rdata = {cfg.max_gain, 2'h0, cfg.ratio};
            default:      rdata = 8'h00;
        endcase
    end

    // Serial slave sequencing: address, index, write bytes, read bytes
    always_comb
    begin
        next_state  = state;
        next_bitcnt = bitcnt;
        next_shreg  = shreg;
        next_index  = index;
        next_drive  = drive;
        next_nack   = nack;
        wr_en       = 1'b0;
        if (bus_stop)
        begin
            next_state = ST_IDLE;
            next_drive = 1'b0;
        end
        else if (bus_start)
        begin
            next_state  = ST_ADDR;
            next_bitcnt = 4'h0;
            next_drive  = 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                    next_drive = 1'b0;
                ST_ADDR, ST_INDEX, ST_WRITE:
                begin
                    if (scl_rise)
                    begin
                        next_shreg  = {shreg[6:0], sda};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    else if (scl_fall && bitcnt == BYTE_BITS)
                    begin
                        next_drive = 1'b1;
                        if (state == ST_ADDR)
                        begin
                            if (shreg == ADDR_WRITE || shreg == ADDR_READ)
                                next_state = ST_ADDR_ACK;
                            else
                            begin
                                next_state = ST_IDLE;
                                next_drive = 1'b0;
                            end
                        end
                        else if (state == ST_INDEX)
                        begin
                            next_index = shreg;
                            next_state = ST_WRITE_ACK;
                        end
                        else
                        begin
                            wr_en      = 1'b1;
                            next_index = index + 8'h01;
                            next_state = ST_WRITE_ACK;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (shreg[0])
                        begin
                            next_shreg  = rdata;
                            next_drive  = ~rdata[7];
                            next_bitcnt = 4'h1;
                            next_index  = index + 8'h01;
                            next_state  = ST_READ;
                        end
                        else
                        begin
                            next_drive  = 1'b0;
                            next_bitcnt = 4'h0;
                            next_state  = ST_INDEX;
                        end
                    end
                end
                ST_WRITE_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_drive  = 1'b0;
                        next_bitcnt = 4'h0;
                        next_state  = ST_WRITE;
                    end
                end
                ST_READ:
                begin
                    if (scl_fall)
                    begin
                        if (bitcnt == BYTE_BITS)
                        begin
                            next_drive = 1'b0;
                            next_state = ST_READ_ACK;
                        end
                        else
                        begin
                            next_drive  = ~shreg[6];
                            next_shreg  = {shreg[6:0], 1'b0};
                            next_bitcnt = bitcnt + 4'h1;
                        end
                    end
                end
                ST_READ_ACK:
                begin
                    if (scl_rise)
                        next_nack = sda;
                    else if (scl_fall)
                    begin
                        if (!nack)
                        begin
                            next_shreg  = rdata;
                            next_drive  = ~rdata[7];
                            next_bitcnt = 4'h1;
                            next_index  = index + 8'h01;
                            next_state  = ST_READ;
                        end
                        else
                            next_state = ST_IDLE;
                    end
                end
                default:
                begin
                    next_state = ST_IDLE;
                    next_drive = 1'b0;
                end
            endcase
        end
    end

    // Serial slave registers; the pin is only ever pulled low
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state   <= ST_IDLE;
            bitcnt  <= 4'h0;
            shreg   <= 8'h00;
            index   <= 8'h00;
            drive   <= 1'b0;
            nack    <= 1'b0;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            bitcnt  <= next_bitcnt;
            shreg   <= next_shreg;
            index   <= next_index;
            drive   <= next_drive;
            nack    <= next_nack;
            scl_q   <= scl;
            sda_q   <= sda;
            sda_oe  <= next_drive;
            sda_out <= 1'b0;
        end
    end

    // Register file writes and hardware flag capture
    always_comb
    begin
        next_right_on      = right_on;
        next_left_on       = left_on;
        next_soft_shutdown = soft_shutdown;
        next_noise_gate_on = noise_gate_on;
        next_cfg           = cfg;
        next_fault_r       = fault_r;
        next_fault_l       = fault_l;
        next_thermal       = thermal;
        if (wr_en)
        begin
            case (index)
                REG_FUNCTION:
                begin
                    next_right_on      = shreg[BIT_RIGHT_ON];
                    next_left_on       = shreg[BIT_LEFT_ON];
                    next_soft_shutdown = shreg[BIT_SHUTDOWN];
                    next_noise_gate_on = shreg[BIT_GATE_ON];
                    next_fault_r       = fault_r & shreg[BIT_FAULT_R];
                    next_fault_l       = fault_l & shreg[BIT_FAULT_L];
                    next_thermal       = thermal & shreg[BIT_THERMAL];
                end
                REG_ATTACK:  next_cfg.gain_drop_interval = shreg[5:0];
                REG_RELEASE: next_cfg.gain_rise_interval = shreg[5:0];
                REG_HOLD:    next_cfg.hold_interval = shreg[5:0];
                REG_GAIN:    next_cfg.base_gain = shreg[5:0];
                REG_LIMITER:
                begin
                    next_cfg.limiter_off    = shreg[7];
                    next_cfg.gate_threshold = shreg[6:5];
                    next_cfg.limiter_level  = shreg[4:0];
                end
                REG_MAXGAIN:
                begin
                    next_cfg.max_gain = shreg[7:4];
                    next_cfg.ratio    = shreg[1:0];
                end
                default:
                    next_cfg = cfg;
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        if (evt.fault_right)
            next_fault_r = 1'b1;
        if (evt.fault_left)
            next_fault_l = 1'b1;
        if (evt.over_temp)
            next_thermal = 1'b1;
    end

    // Register file and registered control outputs
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            right_on             <= RST_FUNCTION[BIT_RIGHT_ON];
            left_on              <= RST_FUNCTION[BIT_LEFT_ON];
            soft_shutdown        <= RST_FUNCTION[BIT_SHUTDOWN];
            fault_r              <= RST_FUNCTION[BIT_FAULT_R];
            fault_l              <= RST_FUNCTION[BIT_FAULT_L];
            thermal              <= RST_FUNCTION[BIT_THERMAL];
            noise_gate_on        <= RST_FUNCTION[BIT_GATE_ON];
            cfg                  <= CFG_RESET;
            right_channel_active <= 1'b0;
            left_channel_active  <= 1'b0;
            core_enabled         <= 1'b0;
            noise_gate_active    <= 1'b0;
            cfg_out              <= CFG_RESET;
        end
        else
        begin
            right_on             <= next_right_on;
            left_on              <= next_left_on;
            soft_shutdown        <= next_soft_shutdown;
            fault_r              <= next_fault_r;
            fault_l              <= next_fault_l;
            thermal              <= next_thermal;
            noise_gate_on        <= next_noise_gate_on;
            cfg                  <= next_cfg;
            right_channel_active <= right_on & ~soft_shutdown & ~evt.over_temp;
            left_channel_active  <= left_on & ~soft_shutdown & ~evt.over_temp;
            core_enabled         <= ~soft_shutdown;
            noise_gate_active    <= noise_gate_on & ~soft_shutdown
                                    & (cfg.ratio != RATIO_ONE_TO_ONE);
            cfg_out              <= cfg;
        end
    end

endmodule : amp_control_bank

// ### amp_bank_asserts.sv
// Port-level checks of the amplifier control bank
`timescale 1ns/1ps
module amp_bank_asserts
    import amp_pkg::*;
(
    input wire logic     clk,
    input wire logic     rstn,
    input wire logic     scl_in,
    input wire logic     sda_out,
    input wire logic     sda_oe,
    input wire logic     over_temp_in,
    input wire logic     right_channel_active,
    input wire logic     left_channel_active,
    input wire logic     core_enabled,
    input wire logic     noise_gate_active,
    input wire amp_cfg_t cfg_out
);
    logic [5:0] hot_cnt;
    logic [5:0] next_hot_cnt;

    // Cycles the over-temperature input has been high, saturating
    always_comb
    begin
        next_hot_cnt = !over_temp_in ? 6'h00 : (hot_cnt == 6'h3F) ? hot_cnt : hot_cnt + 6'h01;
    end

    // Counter register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            hot_cnt <= 6'h00;
        else
            hot_cnt <= next_hot_cnt;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // First sampled edge after reset, and a hot input held past the deglitch
    sequence rst_done;
        $rose(rstn);
    endsequence
    sequence hot_held;
        hot_cnt >= 6'h3C;
    endsequence

    rst_cfg_a: assert property (rst_done |-> cfg_out == CFG_RESET)
        else $error("settings not at defaults after reset");
    shut_off_a: assert property (!core_enabled |->
        !right_channel_active && !left_channel_active && !noise_gate_active)
        else $error("output active in shutdown");
    gate_ratio_a: assert property (noise_gate_active |->
        cfg_out.ratio != RATIO_ONE_TO_ONE)
        else $error("noise gate on at unity ratio");
    hot_right_a: assert property (hot_held |-> !right_channel_active)
        else $error("right channel on while hot");
    hot_left_a: assert property (hot_held |-> !left_channel_active)
        else $error("left channel on while hot");
    drain_low_a: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data pin driven high");
    ack_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data pin moved while bus clock high");
    cfg_move_a: assert property ($changed(cfg_out) |-> !scl_in)
        else $error("settings moved while bus clock high");
endmodule : amp_bank_asserts

bind amp_control_bank amp_bank_asserts u_chk (.clk(clk), .rstn(rstn), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .over_temp_in(over_temp_in),
    .right_channel_active(right_channel_active), .left_channel_active(left_channel_active),
    .core_enabled(core_enabled), .noise_gate_active(noise_gate_active), .cfg_out(cfg_out));

// ### amp_bus_master.sv
// Serial bus master model driving the bank's register port
`timescale 1ns/1ps
module amp_bus_master
    import amp_pkg::*;
(
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_pull
);
    // Idle bus: clock high, data released to the pull-up
    initial
    begin
        scl      <= 1'b1;
        sda_pull <= 1'b0;
    end

    // Wait n clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // One bit: data set in the low half, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        scl <= 1'b0;
        tick(10);
        sda_pull <= !b;
        tick(12);
        scl <= 1'b1;
        tick(11);
        r = sda_line;
        tick(11);
    endtask : bit_io

    // Start or repeated start, and stop
    task automatic start();
        scl <= 1'b0;
        tick(10);
        sda_pull <= 1'b0;
        tick(12);
        scl <= 1'b1;
        tick(22);
        sda_pull <= 1'b1;
        tick(22);
    endtask : start
    task automatic stop();
        scl <= 1'b0;
        tick(10);
        sda_pull <= 1'b1;
        tick(12);
        scl <= 1'b1;
        tick(22);
        sda_pull <= 1'b0;
        tick(22);
    endtask : stop

    // Byte MSB first, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic m_nak, output logic [7:0] q,
                        output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(m_nak, b);
        ack = !b;
    endtask : xfer

    // Write transfer: address byte, index, then data bytes
    task automatic wr(input logic [7:0] a, input logic [7:0] idx, input logic [7:0] q[$],
                      output logic ok);
        logic [7:0] x;
        logic       k;
        start();
        xfer(a, 1'b1, x, ok);
        xfer(idx, 1'b1, x, k);
        ok = ok & k;
        foreach (q[i])
        begin
            xfer(q[i], 1'b1, x, k);
            ok = ok & k;
        end
        stop();
    endtask : wr

    // Read transfer: index write, repeated start, acked bytes, last one refused
    task automatic rd(input logic [7:0] idx, input int n, output logic [7:0] q[$],
                      output logic ok);
        logic [7:0] x;
        logic       k;
        q = {};
        start();
        xfer(ADDR_WRITE, 1'b1, x, ok);
        xfer(idx, 1'b1, x, k);
        ok = ok & k;
        start();
        xfer(ADDR_READ, 1'b1, x, k);
        ok = ok & k;
        for (int i = 0; i < n; i++)
        begin
            xfer(8'hFF, i == n - 1, x, k);
            q.push_back(x);
        end
        stop();
    endtask : rd
endmodule : amp_bus_master

// ### tb_top.sv
// Self-checking bench of the amplifier control bank
`timescale 1ns/1ps
module tb_top
    import amp_pkg::*;
;
    logic       clk, rstn, scl, sda_pull, sda_line, sda_out, sda_oe;
    logic       fr, fl, ot, right, left, core, gate, ok;
    amp_cfg_t   cfg;
    logic [7:0] img [1:7];
    logic [7:0] q [$];
    logic [7:0] w;
    int         fails, checks;
    int         seed = 35;

    // Wired-AND data line with pull-up
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

    amp_bus_master m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
    amp_control_bank DUT (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .fault_right_evt(fr), .fault_left_evt(fl),
        .over_temp_in(ot), .right_channel_active(right), .left_channel_active(left),
        .core_enabled(core), .noise_gate_active(gate), .cfg_out(cfg));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compare, count, report a mismatch
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Counts and verdict, then end of run
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // Expected settings from the register image
    function automatic amp_cfg_t exp_cfg();
        return '{img[2][5:0], img[3][5:0], img[4][5:0], img[5][5:0], img[6][7],
                 img[6][6:5], img[6][4:0], img[7][7:4], img[7][1:0]};
    endfunction : exp_cfg

    // Read n registers from idx and compare with the image
    task automatic rd_chk(input logic [7:0] idx, input int n);
        logic [7:0] r [$];
        logic       k;
        m.rd(idx, n, r, k);
        chk(k, 1'b1);
        foreach (r[i])
            chk(r[i], img[idx + i]);
    endtask : rd_chk

    // Expected control outputs from the image
    task automatic outs(input logic hot);
        logic s = img[1][5];
        chk({right, left, core, gate}, {img[1][7] & !s & !hot, img[1][6] & !s & !hot, !s,
            img[1][0] & !s & (img[7][1:0] != RATIO_ONE_TO_ONE)});
    endtask : outs

    // Hang guard
    initial
    begin
        repeat (90000) @(posedge clk);
        fails++;
        close_out();
    end

    // Reset, then directed and random tests
    initial
    begin
        rstn <= 1'b0;
        {fr, fl, ot} <= 3'b000;
        img = '{8'hC3, 8'h05, 8'h0B, 8'h00, 8'h06, 8'h3A, 8'hC2};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        m.tick(20);
        rd_chk(8'h01, 7);
        outs(1'b0);
        $display("test defaults done");
        // Burst writes of regs 2..7, then a random function control write
        for (int k = 0; k < 3; k++)
        begin
            q = {};
            for (int i = 2; i <= 7; i++)
            begin
                w = $random(seed);
                if (k == 1 && i == 7)
                    w[1:0] = RATIO_ONE_TO_ONE;
                q.push_back(w);
                img[i] = w & ((i == 6) ? 8'hFF : (i == 7) ? 8'hF3 : 8'h3F);
            end
            m.wr(ADDR_WRITE, 8'h02, q, ok);
            chk(ok, 1'b1);
            chk(cfg, exp_cfg());
            rd_chk(8'h02, 6);
            w = $random(seed);
            w[4:2] = 3'b111;
            img[1] = {w[7:5], 3'b000, 1'b1, w[0]};
            m.wr(ADDR_WRITE, 8'h01, {w}, ok);
            rd_chk(8'h01, 1);
            outs(1'b0);
        end
        $display("test burst done");
        img[1] = 8'hC3;
        m.wr(ADDR_WRITE, 8'h01, {img[1]}, ok);
        // Right fault, left fault, over-temperature: glitch then held level
        for (int e = 0; e < 3; e++)
        begin
            {fr, fl, ot} <= 3'b100 >> e;
            m.tick(20);
            {fr, fl, ot} <= 3'b000;
            m.tick(60);
            rd_chk(8'h01, 1);
            {fr, fl, ot} <= 3'b100 >> e;
            m.tick(80);
            outs(e == 2);
            {fr, fl, ot} <= 3'b000;
            m.tick(80);
            img[1][4 - e] = 1'b1;
            rd_chk(8'h01, 1);
            outs(1'b0);
            img[1] = img[1] & 8'hE3;
            m.wr(ADDR_WRITE, 8'h01, {img[1]}, ok);
            rd_chk(8'h01, 1);
        end
        $display("test events done");
        m.wr(8'hA0, 8'h02, {8'h15}, ok);
        chk(ok, 1'b0);
        rd_chk(8'h02, 1);
        $display("test address done");
        close_out();
    end
endmodule : tb_top
